// ===== common/spc_pkg.sv
// Constants and types for the segment protection checker
`default_nettype none
package spc_pkg;
    // Widths
    localparam int SEL_W   = 16;
    localparam int DESC_W  = 64;
    localparam int NSEG    = 6;
    localparam int AW      = 12;
    // Access rights byte inside a cached descriptor
    localparam int AR_LSB  = 40;
    localparam int AR_P    = 7;
    localparam int AR_DPL  = 5;
    localparam int AR_S    = 4;
    localparam int AR_E    = 3;
    localparam int AR_C    = 2;
    localparam int AR_W    = 1;
    // Target selector field of a gate
    localparam int GATE_SEL_LSB = 16;
    // Selector fields
    localparam int SEL_TI  = 2;
    // System descriptor types
    localparam logic [3:0] TY_TASKG    = 4'h5;
    localparam logic [3:0] TY_TSS      = 4'h9;
    localparam logic [3:0] TY_TSS_BUSY = 4'hb;
    localparam logic [3:0] TY_CALLG    = 4'hc;
    localparam logic [3:0] TY_INTG     = 4'he;
    localparam logic [3:0] TY_TRAPG    = 4'hf;
    // Exception vectors
    localparam logic [7:0] VEC_GP = 8'h0d;
    localparam logic [7:0] VEC_SS = 8'h0c;
    // Register byte offsets
    localparam logic [AW-1:0] REG_FLAGS  = 12'h000;
    localparam logic [AW-1:0] REG_STATUS = 12'h004;
    localparam logic [AW-1:0] REG_FCNT   = 12'h008;
    localparam logic [AW-1:0] REG_SEL0   = 12'h010;
    // Field positions in the processor flags register
    localparam int FL_IO_PRIVILEGE_LEVEL = 13;
    localparam int FL_NT   = 16;
    // Reset values
    localparam logic [1:0]  CPL_RST  = 2'h0;
    localparam logic [1:0]  IO_PRIVILEGE_LEVEL_RST = 2'h0;
    localparam logic [15:0] FCNT_RST = 16'h0000;
    // Segment register index
    typedef enum logic [2:0] {
        SEG_CODE, SEG_STACK, SEG_DATA, SEG_EXTRA, SEG_EXTRA2, SEG_EXTRA3
    } spc_seg_t;
    // Operation kinds offered by the core
    typedef enum logic [2:0] {
        OP_LOAD, OP_ACC_RD, OP_ACC_WR, OP_IO, OP_ADJUST_RPL, OP_XFER
    } spc_op_t;
    // Control transfer kinds
    typedef enum logic [2:0] {
        XF_JUMP, XF_CALL, XF_RET, XF_INTERRUPT_EXIT_OP, XF_INT
    } spc_xfer_t;
    // Checker state, Gray along idle-fetch-check-gate
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_FETCH = 2'b01, ST_CHECK = 2'b11, ST_GATE = 2'b10
    } spc_state_t;
    // Request from the core
    typedef struct packed {
        spc_op_t      op;
        spc_seg_t     seg;
        spc_xfer_t    xfer;
        logic [15:0]  sel;
    } spc_req_t;
    // Answer to the core
    typedef struct packed {
        logic         done;
        logic         fault;
        logic [7:0]   vec;
        logic         task_switch;
        logic [15:0]  sel;
    } spc_rsp_t;
endpackage
`default_nettype wire

// ===== rtl/spc_checker.sv
// Segment protection checker: descriptor caches, privilege and transfer checks
//
// How it works
// - New selector fetches and caches 8-byte descriptor
// - Accesses use cache; cache hidden from software
// - Current level always one of four
// - Data access needs effective level at most DESCRIPTOR_PRIVILEGE_LEVEL
// - Code called only from same or lesser level
// - Level changes only via gate to other level or outward return
// - Effective level is larger of current, requestor
// - Adjust op raises requestor bits to current level
// - I/O level in flags bits 13-14, level-0 writes
// - I/O, interrupt-flag, lock ops fault 13 if current>io; the checker has only the I/O op
// - Data registers load data or readable code
// - Privilege check follows type check, fault 13
// - Stack load needs writable data segment
// - Stack DESCRIPTOR_PRIVILEGE_LEVEL and REQUESTOR_PRIVILEGE_LEVEL equal current, else 13
// - Stack not present raises 12
// - Code register load is checked control transfer
// - Level changes only through gates, outward returns or task switch
// - Wrong descriptor type for transfer faults 13
// - Same-level jump/call/return use code segment
// - Call to higher level uses call gate
// - Interrupts vector through trap/interrupt gate
// - Return outward uses code segment, sets level
// - Interrupt exit switches task when nested flag set
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module spc_checker (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  req_valid,
    input  wire spc_pkg::spc_req_t     req,
    output logic                       req_ready,
    output logic                       fetch_valid,
    output logic [15:0]                fetch_sel,
    input  wire logic                  fetch_done,
    input  wire logic [63:0]           fetch_data,
    output spc_pkg::spc_rsp_t          rsp,
    output logic [1:0]                 current_privilege_level,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr
);
    import spc_pkg::*;

    spc_state_t         st_q;          // Sequencer state
    spc_req_t           req_q;         // Request under check
    logic [63:0]        desc_q;        // Descriptor just fetched
    logic               stage_q;       // Set while checking a gate target
    logic [15:0]        tsel_q;        // Gate target selector
    logic [63:0]        cache_q [NSEG]; // Hidden descriptor caches
    logic [15:0]        sel_q [NSEG];  // Visible selectors
    logic [1:0]         cpl_q;         // Current privilege level
    logic [1:0]         io_privilege_level_q;        // I/O privilege level
    logic               nt_q;          // Nested task flag
    logic [15:0]        fcnt_q;        // Faults seen
    logic [7:0]         lastvec_q;     // Vector of the last fault
    spc_rsp_t           rsp_q;         // Registered answer
    logic [31:0]        prdata_q;      // Read data, caught in setup
    logic               perr_q;        // Unmapped address or non-flags write, caught in setup

    // Effective level: the less privileged of the two
    function automatic logic [1:0] epl_of(input logic [1:0] c, input logic [1:0] r);
        epl_of = (c > r) ? c : r;
    endfunction

    // Level of a descriptor
    function automatic logic [1:0] dpl_of(input logic [63:0] d);
        dpl_of = d[AR_LSB+AR_DPL +: 2];
    endfunction

    // Access rights byte of a descriptor
    function automatic logic [7:0] ar_of(input logic [63:0] d);
        ar_of = d[AR_LSB +: 8];
    endfunction

    // Handshake outputs follow the state
    assign req_ready   = (st_q == ST_IDLE);
    assign fetch_valid = (st_q == ST_FETCH) || (st_q == ST_GATE);
    assign rsp         = rsp_q;
    assign current_privilege_level = cpl_q;
    assign pready      = 1'b1;
    assign prdata      = prdata_q;
    assign pslverr     = perr_q;

    logic accept;
    assign accept = req_valid && req_ready;

    // Check of the fetched descriptor
    logic [7:0] ar;
    logic [1:0] dp;
    logic [1:0] rp;
    logic [1:0] ep;
    logic       flt;
    logic [7:0] vec;
    logic       go_gate;
    logic       tsw;
    logic [1:0] cpl_n;
    logic       commit;
    always_comb begin
        ar      = ar_of(desc_q);
        dp      = dpl_of(desc_q);
        rp      = req_q.sel[1:0];
        ep      = epl_of(cpl_q, rp);
        flt     = 1'b0;
        vec     = VEC_GP;
        go_gate = 1'b0;
        tsw     = 1'b0;
        cpl_n   = cpl_q;
        case (req_q.op)
            // Segment register loads
            OP_LOAD: begin
                if (req_q.seg == SEG_STACK) begin
                    if (!(ar[AR_S] && !ar[AR_E] && ar[AR_W])) begin
                        flt = 1'b1;
                    end else if (dp != cpl_q || rp != cpl_q) begin
                        flt = 1'b1;
                    end else if (!ar[AR_P]) begin
                        flt = 1'b1;
                        vec = VEC_SS;
                    end
                end else if (!(ar[AR_S] && (!ar[AR_E] || ar[AR_W]))) begin
                    flt = 1'b1;
                end else if (ep > dp) begin
                    flt = 1'b1;
                end
            end
            // Code register loads, all checked as transfers
            OP_XFER: begin
                if (stage_q) begin
                    // Gate target must be code reachable inward
                    if (!(ar[AR_S] && ar[AR_E]) || dp > cpl_q) begin
                        flt = 1'b1;
                    end else begin
                        cpl_n = dp;
                    end
                end else if (req_q.xfer == XF_INT) begin
                    if (!ar[AR_S] && (ar[3:0] == TY_TRAPG || ar[3:0] == TY_INTG)) begin
                        go_gate = 1'b1;
                    end else if (!ar[AR_S] && ar[3:0] == TY_TASKG) begin
                        tsw = 1'b1;
                    end else begin
                        flt = 1'b1;
                    end
                end else if (req_q.xfer == XF_INTERRUPT_EXIT_OP && nt_q) begin
                    // Nested: back link must be a busy task segment
                    if (!ar[AR_S] && ar[3:0] == TY_TSS_BUSY) begin
                        tsw = 1'b1;
                    end else begin
                        flt = 1'b1;
                    end
                end else if (ar[AR_S] && ar[AR_E]) begin
                    if (req_q.xfer == XF_JUMP || req_q.xfer == XF_CALL) begin
                        // Conforming code may sit inward, level kept
                        if (ar[AR_C] ? (dp > cpl_q) : (dp != cpl_q)) begin
                            flt = 1'b1;
                        end
                    end else if (dp < cpl_q) begin
                        flt = 1'b1;
                    end else begin
                        cpl_n = dp;
                    end
                end else if (!ar[AR_S] && ar[3:0] == TY_CALLG
                             && req_q.xfer == XF_CALL) begin
                    if (ep > dp) begin
                        flt = 1'b1;
                    end else begin
                        go_gate = 1'b1;
                    end
                end else if (!ar[AR_S] && (req_q.xfer == XF_JUMP
                             || req_q.xfer == XF_CALL)
                             && (ar[3:0] == TY_TASKG
                             || (ar[3:0] == TY_TSS && !req_q.sel[SEL_TI]))) begin
                    tsw = 1'b1;    // Task segment only from the global table
                end else begin
                    flt = 1'b1;
                end
            end
            default: begin
                flt = 1'b0;
            end
        endcase
    end

    // Only a clean check that ends the sequence updates state
    assign commit = (st_q == ST_CHECK) && !flt && !go_gate;

    // Sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (accept && (req.op == OP_LOAD || req.op == OP_XFER)) begin
                        st_q <= ST_FETCH;
                    end
                end
                ST_FETCH, ST_GATE: begin
                    if (fetch_done) begin
                        st_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    st_q <= go_gate ? ST_GATE : ST_IDLE;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Request, fetched descriptor and fetch address
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_q     <= '0;
            desc_q    <= '0;
            stage_q   <= 1'b0;
            tsel_q    <= '0;
            fetch_sel <= '0;
        end else begin
            if (accept) begin
                req_q     <= req;
                stage_q   <= 1'b0;
                fetch_sel <= req.sel;
            end
            if (fetch_valid && fetch_done) begin
                desc_q <= fetch_data;
            end
            if (st_q == ST_CHECK && go_gate) begin
                // Second fetch walks to the code the gate names
                stage_q   <= 1'b1;
                tsel_q    <= desc_q[GATE_SEL_LSB +: 16];
                fetch_sel <= desc_q[GATE_SEL_LSB +: 16];
            end
        end
    end

    // Selectors and hidden caches change only on a clean load
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NSEG; i++) begin
                sel_q[i]   <= '0;
                cache_q[i] <= '0;
            end
        end else if (commit && !tsw) begin
            if (req_q.op == OP_LOAD) begin
                sel_q[req_q.seg]   <= req_q.sel;
                cache_q[req_q.seg] <= desc_q;
            end else if (req_q.op == OP_XFER) begin
                sel_q[SEG_CODE]   <= stage_q ? tsel_q : req_q.sel;
                cache_q[SEG_CODE] <= desc_q;
            end
        end
    end

    // Current level: reset to most privileged, moved only by transfers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpl_q <= CPL_RST;
        end else if (commit && req_q.op == OP_XFER) begin
            cpl_q <= cpl_n;
        end
    end

    // Checks that need no fetch, made from the caches and the level registers
    logic [63:0] cd;
    logic [7:0]  car;
    logic        iflt;
    logic [15:0] isel;
    always_comb begin
        cd   = cache_q[req.seg];
        car  = ar_of(cd);
        iflt = 1'b0;
        isel = req.sel;
        case (req.op)
            OP_ACC_RD: begin
                // Execute-only code may not be read
                iflt = (car[AR_E] && !car[AR_W])
                       || (epl_of(cpl_q, sel_q[req.seg][1:0]) > dpl_of(cd));
            end
            OP_ACC_WR: begin
                iflt = car[AR_E] || !car[AR_W]
                       || (epl_of(cpl_q, sel_q[req.seg][1:0]) > dpl_of(cd));
            end
            OP_IO: begin
                iflt = cpl_q > io_privilege_level_q;
            end
            OP_ADJUST_RPL: begin
                if (req.sel[1:0] < cpl_q) begin
                    isel = {req.sel[15:2], cpl_q};
                end
            end
            default: begin
                iflt = 1'b0;
            end
        endcase
    end

    // Answer to the core, one cycle wide
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= '0;
            if (accept && req.op != OP_LOAD && req.op != OP_XFER) begin
                rsp_q.done  <= 1'b1;
                rsp_q.fault <= iflt;
                rsp_q.vec   <= iflt ? VEC_GP : 8'h00;
                rsp_q.sel   <= isel;
            end else if (st_q == ST_CHECK && !go_gate) begin
                rsp_q.done        <= 1'b1;
                rsp_q.fault       <= flt;
                rsp_q.vec         <= flt ? vec : 8'h00;
                rsp_q.task_switch <= tsw;
                rsp_q.sel         <= stage_q ? tsel_q : req_q.sel;
            end
        end
    end

    // Fault bookkeeping for software
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fcnt_q    <= FCNT_RST;
            lastvec_q <= 8'h00;
        end else if (rsp_q.done && rsp_q.fault) begin
            fcnt_q    <= fcnt_q + 16'h0001;
            lastvec_q <= rsp_q.vec;
        end
    end

    // Flags register; I/O level guarded by the current level
    logic wr_en;
    assign wr_en = psel && penable && pwrite;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            io_privilege_level_q <= IO_PRIVILEGE_LEVEL_RST;
            nt_q   <= 1'b0;
        end else if (wr_en && paddr == REG_FLAGS) begin
            nt_q <= pwdata[FL_NT];
            if (cpl_q == 2'h0) begin
                io_privilege_level_q <= pwdata[FL_IO_PRIVILEGE_LEVEL +: 2];
            end
        end
    end

    // Read path, caught in the setup phase so access data is a flop.
    // The caches have no address at all, so software can never see them.
    logic [31:0] rd;
    logic        rd_err;
    logic [11:0] sidx;
    always_comb begin
        rd     = 32'h0000_0000;
        rd_err = 1'b0;
        sidx   = (paddr - REG_SEL0) >> 2;
        if (paddr == REG_FLAGS) begin
            rd[FL_IO_PRIVILEGE_LEVEL +: 2] = io_privilege_level_q;
            rd[FL_NT]        = nt_q;
        end else if (paddr == REG_STATUS) begin
            rd[1:0]  = cpl_q;
            rd[3:2]  = st_q;
            rd[15:8] = lastvec_q;
        end else if (paddr == REG_FCNT) begin
            rd[15:0] = fcnt_q;
        end else if (paddr >= REG_SEL0 && paddr[1:0] == 2'b00
                     && sidx < 12'(NSEG)) begin
            rd[15:0] = sel_q[sidx[2:0]];
        end else begin
            rd_err = 1'b1;
        end
    end

    // Bus answer registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_q <= '0;
            perr_q   <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd;
            perr_q   <= rd_err || (pwrite && paddr != REG_FLAGS);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_io_fault_gp: assert property (
        accept && req.op == OP_IO && cpl_q > io_privilege_level_q
        |=> rsp.done && rsp.fault && rsp.vec == VEC_GP)
        else $error("io op above io level not refused");

    chk_cpl_only_xfer: assert property (
        !$stable(cpl_q) |-> $past(commit) && $past(req_q.op) == OP_XFER)
        else $error("current level moved outside a transfer");

    chk_cache_hold: assert property (
        !$stable(sel_q[SEG_DATA]) |-> $past(commit) && !$past(tsw))
        else $error("data selector changed without clean load");

    chk_stack_absent: assert property (
        st_q == ST_CHECK && req_q.op == OP_LOAD && req_q.seg == SEG_STACK
        && ar[AR_S] && !ar[AR_E] && ar[AR_W] && dp == cpl_q
        && rp == cpl_q && !ar[AR_P]
        |=> rsp.fault && rsp.vec == VEC_SS)
        else $error("absent stack did not raise 12");

    chk_adjust_rpl: assert property (
        accept && req.op == OP_ADJUST_RPL && req.sel[1:0] < cpl_q
        |=> rsp.done && rsp.sel[1:0] == $past(cpl_q))
        else $error("requestor bits not raised");

    chk_load_fetch: assert property (
        accept && req.op == OP_LOAD
        |=> fetch_valid && fetch_sel == $past(req.sel))
        else $error("load did not fetch its descriptor");

    chk_io_privilege_level_guard: assert property (
        cpl_q != 2'h0 |=> io_privilege_level_q == $past(io_privilege_level_q))
        else $error("io level changed away from level 0");

    chk_data_epl: assert property (
        st_q == ST_CHECK && req_q.op == OP_LOAD && req_q.seg == SEG_DATA
        && ep > dp |=> rsp.done && rsp.fault)
        else $error("data load above effective level passed");

    chk_stack_level: assert property (
        st_q == ST_CHECK && req_q.op == OP_LOAD && req_q.seg == SEG_STACK
        && rp != cpl_q |=> rsp.done && rsp.fault && rsp.vec == VEC_GP)
        else $error("stack requestor mismatch passed");

endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the segment protection checker
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import spc_pkg::*;
    logic               clk;          // 50 MHz core clock
    logic               rst_n;        // Synchronous reset, active low
    logic               req_valid;    // Core request strobe
    spc_req_t           req;          // Core request
    logic               req_ready;
    logic               fetch_valid;
    logic [15:0]        fetch_sel;
    logic               fetch_done;   // Descriptor returned by memory side
    logic [63:0]        fetch_data;
    spc_rsp_t           rsp;
    logic [1:0]         current_privilege_level;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [63:0]        desc;         // Descriptor the memory side will hand back
    logic [63:0]        desc2;        // Code descriptor that a gate names
    logic               hop;          // Set once a request's first fetch is answered
    logic [15:0]        cur_sel;      // Selector of the request in flight
    logic [26:0]        expq[$];      // Notes: {task switch, check sel, fault, vector, sel}
    logic [26:0]        e;
    int                 miscompares;
    int                 comparisons;
    int                 i;

    spc_checker dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .fetch_valid(fetch_valid), .fetch_sel(fetch_sel),
        .fetch_done(fetch_done), .fetch_data(fetch_data), .rsp(rsp),
        .current_privilege_level(current_privilege_level), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // Clock generator
    always #10 clk = ~clk;

    // One comparison; four-state equality so unknowns never pass
    task automatic chk(string name, logic [31:0] ex, logic [31:0] seen);
        comparisons++;
        if (seen !== ex) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, ex, seen);
        end
    endtask

    // Verdict and end of run
    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Build a descriptor around its access byte and a gate's target selector
    function automatic logic [63:0] dsc(logic [7:0] ar, logic [15:0] t);
        return {16'h0000, ar, 8'h00, t, 16'h0000};
    endfunction

    // Memory side: answers fetches after a random stall; junk on the bus otherwise
    always @(posedge clk) begin
        fetch_done <= 1'b0;
        fetch_data <= {$urandom, $urandom};
        if (req_ready === 1'b1) begin
            hop <= 1'b0;
        end
        // A second fetch of one request walks to the code that the gate names
        if (fetch_valid === 1'b1 && !fetch_done && $urandom_range(0, 1) == 1) begin
            chk("fetch_sel", {16'h0, hop ? desc[31:16] : cur_sel}, {16'h0, fetch_sel});
            fetch_done <= 1'b1;
            fetch_data <= hop ? desc2 : desc;
            hop <= 1'b1;
        end
    end

    // Monitor: each done pulse consumes the oldest note
    always @(posedge clk) begin
        if (rsp.done === 1'b1) begin
            if (expq.size() == 0) begin
                chk("unexpected done", 32'h0, 32'h1);
            end else begin
                e = expq.pop_front();
                chk("fault", {31'h0, e[24]}, {31'h0, rsp.fault});
                chk("vector", {24'h0, e[23:16]}, {24'h0, rsp.vec});
                chk("task_switch", {31'h0, e[26]}, {31'h0, rsp.task_switch});
                if (e[25]) begin
                    chk("rsp_sel", {16'h0000, e[15:0]}, {16'h0000, rsp.sel});
                end
            end
        end
    end

    // Core request; waits for the answer under a bound
    // cs: bit 1 task switch expected, bit 0 answer selector checked
    task automatic core(spc_op_t op, spc_seg_t sg, spc_xfer_t xf, logic [15:0] s,
                        logic [7:0] ar, logic [7:0] v, logic [1:0] cs, logic [15:0] es);
        int n;
        desc = dsc(ar, s + 16'h0018);
        cur_sel = s;
        expq.push_back({cs, v != 8'h00, v, es});
        req_valid <= 1'b1;
        req <= '{op, sg, xf, s};
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        req <= '{OP_IO, SEG_CODE, XF_JUMP, 16'(~s)};
        for (n = 0; n < 60 && expq.size() != 0; n++) @(posedge clk);
        if (expq.size() != 0) begin
            chk("answer", 32'h1, 32'h0);
            expq.delete();
        end
    endtask

    // APB transfer: setup, access until pready, then release and one idle edge
    task automatic apb(logic w, logic [11:0] a, logic [31:0] wd, logic [31:0] ex, logic er);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        if (!w) begin
            chk("prdata", ex, prdata);
        end
        chk("pslverr", {31'h0, er}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end

    // Main sequence
    initial begin
        clk = 1'b0; rst_n = 1'b0; req_valid = 1'b0; req = '0; fetch_done = 1'b0;
        fetch_data = '0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
        pwdata = '0; desc = '0; desc2 = '0; cur_sel = '0; miscompares = 0; comparisons = 0;
        void'($urandom(32'hed0cff2f));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("level", 32'h0, {30'h0, current_privilege_level});
        apb(0, REG_FLAGS, 0, 32'h0, 0);
        apb(1, REG_FLAGS, 32'h2000, 0, 0);
        apb(0, REG_FLAGS, 0, 32'h2000, 0);
        apb(0, 12'h0fc, 0, 32'h0, 1);
        apb(1, REG_STATUS, 32'h3, 0, 1);
        core(OP_IO, SEG_CODE, XF_JUMP, 16'h0, 8'h00, 8'h00, 0, 0);
        core(OP_ADJUST_RPL, SEG_DATA, XF_JUMP, 16'h0010, 8'h00, 8'h00, 1, 16'h0010);
        core(OP_XFER, SEG_CODE, XF_RET, 16'h0023, 8'hfa, 8'h00, 0, 0);
        chk("level", 32'h3, {30'h0, current_privilege_level});
        core(OP_IO, SEG_CODE, XF_JUMP, 16'h0, 8'h00, VEC_GP, 0, 0);
        apb(1, REG_FLAGS, 32'h0, 0, 0);
        apb(0, REG_FLAGS, 0, 32'h2000, 0);
        core(OP_ADJUST_RPL, SEG_DATA, XF_JUMP, 16'h0010, 8'h00, 8'h00, 1, 16'h0013);
        core(OP_LOAD, SEG_DATA, XF_JUMP, 16'h002b, 8'hf2, 8'h00, 0, 0);
        apb(0, REG_SEL0 + 12'h008, 0, 32'h2b, 0);
        core(OP_LOAD, SEG_DATA, XF_JUMP, 16'h0033, 8'h92, VEC_GP, 0, 0);
        core(OP_LOAD, SEG_DATA, XF_JUMP, 16'h0033, 8'he9, VEC_GP, 0, 0);
        core(OP_LOAD, SEG_DATA, XF_JUMP, 16'h0033, 8'hf8, VEC_GP, 0, 0);
        apb(0, REG_SEL0 + 12'h008, 0, 32'h2b, 0);
        core(OP_ACC_RD, SEG_DATA, XF_JUMP, 16'h0, 8'h00, 8'h00, 0, 0);
        // Random selectors through every data register, readable code accepted too
        for (i = 0; i < 4; i++) begin
            cur_sel = {13'($urandom_range(1, 8191)), 1'b0, 2'b11};
            core(OP_LOAD, spc_seg_t'(2 + i), XF_JUMP, cur_sel, 8'hfa, 8'h00, 0, 0);
            apb(0, REG_SEL0 + 12'(8 + 4 * i), 0, {16'h0, cur_sel}, 0);
        end
        core(OP_LOAD, SEG_STACK, XF_JUMP, 16'h0043, 8'hf2, 8'h00, 0, 0);
        core(OP_LOAD, SEG_STACK, XF_JUMP, 16'h004b, 8'hf0, VEC_GP, 0, 0);
        core(OP_LOAD, SEG_STACK, XF_JUMP, 16'h004b, 8'hd2, VEC_GP, 0, 0);
        core(OP_LOAD, SEG_STACK, XF_JUMP, 16'h004a, 8'hf2, VEC_GP, 0, 0);
        core(OP_LOAD, SEG_STACK, XF_JUMP, 16'h004b, 8'h72, VEC_SS, 0, 0);
        apb(0, REG_SEL0 + 12'h004, 0, 32'h43, 0);
        core(OP_XFER, SEG_CODE, XF_JUMP, 16'h0053, 8'hf2, VEC_GP, 0, 0);
        core(OP_XFER, SEG_CODE, XF_CALL, 16'h0053, 8'he9, 8'h00, 2'b10, 0);
        chk("level", 32'h3, {30'h0, current_privilege_level});
        core(OP_ACC_WR, SEG_STACK, XF_JUMP, 16'h0, 8'h00, 8'h00, 0, 0);
        core(OP_ACC_WR, SEG_DATA, XF_JUMP, 16'h0, 8'h00, VEC_GP, 0, 0);
        core(OP_XFER, SEG_CODE, XF_INTERRUPT_EXIT_OP, 16'h0063, 8'hfa, 8'h00, 0, 0);
        desc2 = dsc(8'h9a, 16'h0000);
        core(OP_XFER, SEG_CODE, XF_INT, 16'h0070, 8'hef, 8'h00, 1, 16'h0088);
        chk("level", 32'h0, {30'h0, current_privilege_level});
        desc2 = dsc(8'hfa, 16'h0000);
        core(OP_XFER, SEG_CODE, XF_CALL, 16'h0078, 8'hec, VEC_GP, 1, 16'h0090);
        chk("level", 32'h0, {30'h0, current_privilege_level});
        apb(1, REG_FLAGS, 32'h10000, 0, 0);
        apb(0, REG_FLAGS, 0, 32'h10000, 0);
        core(OP_XFER, SEG_CODE, XF_INTERRUPT_EXIT_OP, 16'h0063, 8'hfa, VEC_GP, 0, 0);
        core(OP_XFER, SEG_CODE, XF_INTERRUPT_EXIT_OP, 16'h0063, 8'heb, 8'h00, 2'b10, 0);
        final_report();
    end
endmodule
`default_nettype wire
